// ==== rtl/ata_port_pkg.sv ====
// Package for the device-side ATA DMA handshake port.
// Assumes a single 25 MHz reference clock domain; all pins are sampled inside.
package ata_port_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int DATA_W        = 16;     // Every DMA transfer moves one full word.
    localparam int REF_CLK_NS    = 40;     // Reference clock period in ns.
    localparam int STROBE_HALF_NS = 80;    // Least half period of the device data-in strobe.
    // Least half period rounded up to whole clock cycles, never below one.
    localparam int STROBE_HALF_CYC = (STROBE_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int SYNC_STAGES   = 2;      // Flip-flops on a pin input, ahead of all logic but its inversion and the chip select OR.

    // Host-side strobe and control pins, after synchronisation, active high.
    typedef struct packed {
        logic dmack;       // Host acknowledges the DMA request.
        logic stop;        // Host ends the burst.
        logic hrdy;        // Host ready for data-in words.
        logic hstrobe;     // Host data-out strobe level.
        logic rd;          // Register read strobe.
        logic wr;          // Register write strobe.
        logic cs_any;      // Either chip select active.
    } host_pins_t;

    // Burst sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_DIN, ST_DOUT, ST_DONE
    } burst_state_t;

endpackage : ata_port_pkg

// ==== rtl/ata_pin_sync.sv ====
// Two-flip-flop synchroniser bank for the host pins.
// Assumes inputs are asynchronous to REF_CLK; only the second stage is read.
`timescale 1ns/1ps
module ata_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Raw and synchronised levels.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;  // First stage, read only by the second stage.

    // Both stages reset to zero; the pins are active-high copies here.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : ata_pin_sync

// ==== rtl/ata_dma_handshake_port.sv ====
// Device-side handshake logic for a parallel ATA host port with Ultra DMA.
// Assumes a 25 MHz REF_CLK; all host pins are asynchronous and synchronised here.
// Summary of operation
// - Hold ready low until register access served.
// - Assert device ready during data-out burst.
// - Drop device ready to pause data-out.
// - Toggle data-in strobe, one word per edge.
// - Hold data-in strobe steady to pause.
// - Grounded cable select means master, open slave.
// - Request DMA only once transfer is prepared.
// - Drop request on acknowledge, re-raise if more.
// - DMA always moves full 16-bit words.
// - Capture data-out word on both strobe edges.
// - Host stop or dropped acknowledge ends burst.
`timescale 1ns/1ps
module ata_dma_handshake_port
    import ata_port_pkg::*;
#(
    parameter int DW = DATA_W
) (
    // ************************************************************
    // Clock and reset
    // ************************************************************
    input  wire logic          REF_CLK_I,
    input  wire logic          RST_N_I,
    // Host pins (raw, polarity as on the cable; STOP_I is active high).
    input  wire logic          DMACK_N_I,
    input  wire logic          STOP_I,
    input  wire logic          HDMARDY_N_I,
    input  wire logic          HSTROBE_I,
    input  wire logic          DIOR_N_I,
    input  wire logic          DIOW_N_I,
    input  wire logic          CS0_N_I,
    input  wire logic          CS1_N_I,
    input  wire logic          CSEL_I,
    // Data bus pin as three signals.
    input  wire logic [DW-1:0] DATA_I,
    output logic      [DW-1:0] DATA_O,
    output logic               DATA_OE_O,
    // Device pins to the host.
    output logic               DMARQ_O,
    output logic               DDMARDY_N_O,
    output logic               DSTROBE_O,
    output logic               IORDY_O,
    // Core side: burst control.
    input  wire logic          XFER_READY_I,
    input  wire logic          XFER_DIR_IN_I,
    input  wire logic          REG_READY_I,
    // Core side: data-in words to host.
    input  wire logic [DW-1:0] TX_DATA_I,
    input  wire logic          TX_VALID_I,
    output logic               TX_READY_O,
    // Core side: data-out words from host.
    input  wire logic          RX_READY_I,
    output logic [DW-1:0]      RX_DATA_O,
    output logic               RX_VALID_O,
    // Status.
    output logic               IS_MASTER_O,
    output logic               BURST_ACTIVE_O
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    host_pins_t raw;           // Active-high copy of raw pins.
    host_pins_t hp;            // Synchronised pins.
    logic [DW-1:0] din_s1_q;   // First data stage, read only by the second.
    logic [DW-1:0] din_q;      // Synchronised data bus.
    logic          csel_s1_q;  // First cable select stage.
    logic          csel_q;     // Synchronised cable select.

    always_comb begin
        raw.dmack   = ~DMACK_N_I;
        raw.stop    = STOP_I;
        raw.hrdy    = ~HDMARDY_N_I;
        raw.hstrobe = HSTROBE_I;
        raw.rd      = ~DIOR_N_I;
        raw.wr      = ~DIOW_N_I;
        raw.cs_any  = ~CS0_N_I | ~CS1_N_I;
    end

    ata_pin_sync #(.W($bits(host_pins_t))) u_sync (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .async_i (raw),
        .sync_o  (hp)
    );

    // Data and cable select pass two stages too; data is delayed with strobe alike.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            din_s1_q  <= '0;
            din_q     <= '0;
            csel_s1_q <= 1'b1;
            csel_q    <= 1'b1;
        end else begin
            din_s1_q  <= DATA_I;
            din_q     <= din_s1_q;
            csel_s1_q <= CSEL_I;
            csel_q    <= csel_s1_q;
        end
    end

    // ************************************************************
    // Master or slave strap
    // ************************************************************
    logic       strap_done_q;  // Strap caught once after reset release.
    logic [1:0] strap_wait_q;  // Edges waited while the strap crosses the synchroniser.
    logic       master_q;      // Low cable select means master.

    // Caught by a clocked process after release, never in the reset branch.
    // Waiting for the synchroniser to fill avoids latching its reset value as the strap.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            strap_done_q <= 1'b0;
            strap_wait_q <= '0;
            master_q     <= 1'b0;
        end else if (!strap_done_q) begin
            if (strap_wait_q == 2'(SYNC_STAGES)) begin
                strap_done_q <= 1'b1;
                master_q     <= ~csel_q;
            end else begin
                strap_wait_q <= strap_wait_q + 2'h1;
            end
        end
    end
    assign IS_MASTER_O = master_q;

    // ************************************************************
    // Register cycle stretching
    // ************************************************************
    logic reg_cycle;  // Host register cycle in progress.
    assign reg_cycle = hp.cs_any & (hp.rd | hp.wr);

    // Ready stays low during a register cycle until the core can answer.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) IORDY_O <= 1'b1;
        else          IORDY_O <= ~reg_cycle | REG_READY_I;
    end

    // ************************************************************
    // Burst sequencer
    // ************************************************************
    burst_state_t state_q;    // Current burst state.
    logic         hstb_q;     // Previous host strobe level.
    logic [3:0]   half_cnt_q; // Strobe half period counter.
    logic         strobe_q;   // Device data-in strobe level.
    logic         word_due;   // Next data-in edge allowed.

    assign BURST_ACTIVE_O = (state_q == ST_DIN) | (state_q == ST_DOUT);
    // The host must keep chip selects idle during DMA; a register cycle never starts a burst.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (XFER_READY_I && !hp.cs_any) state_q <= ST_REQ;
                ST_REQ:  if (hp.dmack) state_q <= XFER_DIR_IN_I ? ST_DIN : ST_DOUT;
                ST_DIN:  if (hp.stop || !hp.dmack) state_q <= ST_DONE;
                ST_DOUT: if (hp.stop || !hp.dmack) state_q <= ST_DONE;
                ST_DONE: if (!hp.dmack) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Request stands in REQ only; falls on acknowledge, rises again for more data.
    assign DMARQ_O = (state_q == ST_REQ) & ~hp.dmack;

    // ************************************************************
    // Data-in: device strobes words to the host
    // ************************************************************
    assign word_due = (state_q == ST_DIN) & hp.dmack & hp.hrdy & ~hp.stop
                      & (half_cnt_q == 4'(STROBE_HALF_CYC - 1));
    assign TX_READY_O = word_due;

    // Strobe toggles once per word; it holds when host pauses or no word is ready.
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            strobe_q   <= 1'b1;
            half_cnt_q <= '0;
            DATA_O     <= '0;
        end else if (state_q != ST_DIN) begin
            strobe_q   <= 1'b1;
            half_cnt_q <= '0;
        end else if (word_due && TX_VALID_I) begin
            DATA_O     <= TX_DATA_I;
            strobe_q   <= ~strobe_q;
            half_cnt_q <= '0;
        end else if (half_cnt_q != 4'(STROBE_HALF_CYC - 1)) begin
            half_cnt_q <= half_cnt_q + 4'h1;
        end
    end
    assign DSTROBE_O = strobe_q;
    assign DATA_OE_O = (state_q == ST_DIN) & hp.dmack;

    // ************************************************************
    // Data-out: device captures words on both host strobe edges
    // ************************************************************
    logic out_rdy;  // Device can take a word.
    assign out_rdy = (state_q == ST_DOUT) & hp.dmack & (~RX_VALID_O | RX_READY_I);
    assign DDMARDY_N_O = ~out_rdy;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hstb_q     <= 1'b0;
            RX_DATA_O  <= '0;
            RX_VALID_O <= 1'b0;
        end else begin
            hstb_q <= hp.hstrobe;
            if ((state_q == ST_DOUT) && (hp.hstrobe != hstb_q)) begin
                RX_DATA_O  <= din_q;
                RX_VALID_O <= 1'b1;
            end else if (RX_READY_I) begin
                RX_VALID_O <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_IORDY_STRETCH: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (reg_cycle && !REG_READY_I) |=> !IORDY_O) else $error("ready not stretched");
    AST_DRDY_ONLY_DOUT: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        !DDMARDY_N_O |-> (state_q == ST_DOUT)) else $error("device ready outside data-out");
    AST_DRDY_PAUSE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (RX_VALID_O && !RX_READY_I) |-> DDMARDY_N_O) else $error("ready while full");
    AST_STROBE_EDGE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_DIN && word_due && TX_VALID_I) |=> (DSTROBE_O != $past(DSTROBE_O)))
        else $error("no strobe edge for word");
    AST_STROBE_PAUSE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_DIN && !hp.hrdy) |=> $stable(DSTROBE_O)) else $error("edge in pause");
    AST_RQ_DROP: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        hp.dmack |-> !DMARQ_O) else $error("request under acknowledge");
    AST_RQ_PREP: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_IDLE && !XFER_READY_I) |=> !DMARQ_O) else $error("early request");
    AST_CAPTURE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (state_q == ST_DOUT && hp.hstrobe != hstb_q) |=> (RX_VALID_O && RX_DATA_O == $past(din_q)))
        else $error("word not captured");
    AST_STOP_ENDS: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (BURST_ACTIVE_O && hp.stop) |=> (state_q == ST_DONE)) else $error("stop ignored");
    AST_IDLE_OUT: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        !hp.dmack |-> (DDMARDY_N_O && !DATA_OE_O)) else $error("outputs active without ack");
    AST_MASTER: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $rose(strap_done_q) |-> (master_q == !$past(csel_q))) else $error("wrong strap");

    COV_DIN: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        state_q == ST_REQ ##1 state_q == ST_DIN);
    COV_DOUT: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        state_q == ST_DOUT && hp.hstrobe != hstb_q);
    COV_STOP: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        BURST_ACTIVE_O && hp.stop);
    COV_STRETCH: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I) !IORDY_O);

endmodule : ata_dma_handshake_port

// ==== tb/ata_host_model.sv ====
// Behavioural host controller facing the ATA handshake port.
// Assumes the bench calls one task at a time; pins move at falling edges only.
`timescale 1ns/1ps
module ata_host_model (
    // Clock and device pins.
    input  wire logic        clk_i,
    input  wire logic        dmarq_i,
    input  wire logic        ddmardy_n_i,
    // Host pins.
    output logic             dmack_n_o,
    output logic             stop_o,
    output logic             hdmardy_n_o,
    output logic             hstrobe_o,
    output logic             dior_n_o,
    output logic             diow_n_o,
    output logic             cs0_n_o,
    output logic             cs1_n_o,
    output logic [15:0]      data_o
);
    // Idle host: nothing selected, write strobe negated before any burst.
    initial begin
        {dmack_n_o, hdmardy_n_o, dior_n_o, diow_n_o, cs0_n_o, cs1_n_o} = 6'h3F;
        {stop_o, hstrobe_o} = 2'b00;
        data_o = 16'h0000;
    end
    // Register cycle: chip select and read strobe together.
    task automatic reg_set(input logic on);
        cs0_n_o = ~on;
        dior_n_o = ~on;
    endtask : reg_set
    // Host ready for data-in words; withdrawing it pauses the device.
    task automatic host_rdy(input logic on);
        hdmardy_n_o = ~on;
    endtask : host_rdy
    // Wait a bounded time for the request, then acknowledge it.
    task automatic ack(output logic ok);
        int n;
        n = 0;
        while (dmarq_i !== 1'b1 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        ok = (n < 60);
        dmack_n_o = 1'b0;
    endtask : ack
    // Data-out words, one per strobe edge, 160 ns apart; pauses while the device is not ready.
    task automatic send(input int cnt, input logic [15:0] base);
        int w;
        for (int k = 0; k < cnt; k++) begin
            data_o = base + k[15:0];
            repeat (2) @(negedge clk_i);
            w = 0;
            while (ddmardy_n_i !== 1'b0 && w < 100) begin
                @(negedge clk_i);
                w++;
            end
            hstrobe_o = ~hstrobe_o;
            repeat (2) @(negedge clk_i); // Hold the word past the strobe edge.
        end
        repeat (4) @(negedge clk_i);
        data_o = ~data_o; // Released bus must not keep the last word.
    endtask : send
    // Stop ends the burst, then the acknowledge is withdrawn.
    task automatic finish_burst;
        stop_o = 1'b1;
        repeat (4) @(negedge clk_i);
        dmack_n_o = 1'b1;
        stop_o = 1'b0;
    endtask : finish_burst
endmodule : ata_host_model

// ==== tb/test_ata_dma_handshake_port.sv ====
// Self-checking bench for the device-side ATA DMA handshake port.
// Assumes the host model in ata_host_model.sv; core side driven at falling edges.
`timescale 1ns/1ps
module test_ata_dma_handshake_port;
    import ata_port_pkg::*;
    logic clk, rst_n, csel, xfer, dir_in, reg_rdy, tx_valid, rx_rdy, ok;
    logic dmack_n, stop, hrdy_n, hstb, dior_n, diow_n, cs0_n, cs1_n, dstb_prev, rx_valid_prev;
    logic [15:0] hdata, dout, tx_data, rx_data;
    logic oe, dmarq, ddmardy_n, dstb, iordy, tx_rdy, rx_valid, is_master, active;
    int error_cnt = 0, checks = 0, tx_n = 0, din_n = 0, rx_n = 0;
    ata_dma_handshake_port dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .DMACK_N_I(dmack_n),
        .STOP_I(stop), .HDMARDY_N_I(hrdy_n), .HSTROBE_I(hstb), .DIOR_N_I(dior_n),
        .DIOW_N_I(diow_n), .CS0_N_I(cs0_n), .CS1_N_I(cs1_n), .CSEL_I(csel), .DATA_I(hdata),
        .DATA_O(dout), .DATA_OE_O(oe), .DMARQ_O(dmarq), .DDMARDY_N_O(ddmardy_n),
        .DSTROBE_O(dstb), .IORDY_O(iordy), .XFER_READY_I(xfer), .XFER_DIR_IN_I(dir_in),
        .REG_READY_I(reg_rdy), .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_rdy),
        .RX_READY_I(rx_rdy), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
        .IS_MASTER_O(is_master), .BURST_ACTIVE_O(active));
    ata_host_model host (.clk_i(clk), .dmarq_i(dmarq), .ddmardy_n_i(ddmardy_n),
        .dmack_n_o(dmack_n), .stop_o(stop), .hdmardy_n_o(hrdy_n), .hstrobe_o(hstb),
        .dior_n_o(dior_n), .diow_n_o(diow_n), .cs0_n_o(cs0_n), .cs1_n_o(cs1_n), .data_o(hdata));
    // 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Core feed: a new data-in word lands at the falling edge after each take.
    always @(posedge clk) if (tx_valid && tx_rdy) tx_n <= tx_n + 1;
    always @(negedge clk) tx_data <= 16'hA000 + tx_n[15:0];
    // Every strobe edge while driving carries the next word; a data-out word is counted
    // once the core has taken it, seen as the fall of its valid flag.
    always @(negedge clk) begin
        if (oe === 1'b1 && dstb !== dstb_prev) begin
            check(dout, 16'hA000 + din_n[15:0], "data-in word");
            din_n++;
        end
        dstb_prev = dstb;
        if (rx_valid !== 1'b1 && rx_valid_prev === 1'b1) begin
            check(rx_data, 16'h5000 + rx_n[15:0], "data-out word");
            rx_n++;
        end
        rx_valid_prev = rx_valid;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // Reset for two cycles with a given strap, then let the strap settle.
    task automatic do_reset(input logic strap);
        csel = strap;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : do_reset
    task automatic t_strap;
        do_reset(1'b1);
        check(is_master, 1'b0, "open strap");
        do_reset(1'b0);
        check(is_master, 1'b1, "grounded strap");
        check({dmarq, ddmardy_n, dstb, iordy, oe}, 5'b01110, "idle pins");
        $display("strap test done");
    endtask : t_strap
    // Register cycle stretched until the core can answer.
    task automatic t_reg;
        reg_rdy = 1'b0;
        host.reg_set(1'b1);
        repeat (4) @(negedge clk);
        check(iordy, 1'b0, "ready held low");
        reg_rdy = 1'b1;
        repeat (3) @(negedge clk);
        check(iordy, 1'b1, "ready released");
        host.reg_set(1'b0);
        $display("register test done");
    endtask : t_reg
    // Data-in burst with a host pause and a stop.
    task automatic t_din;
        int n0;
        dir_in = 1'b1;
        tx_valid = 1'b1;
        repeat (3) @(negedge clk);
        check(dmarq, 1'b0, "no request unprepared");
        xfer = 1'b1;
        host.ack(ok);
        check(ok, 1'b1, "request raised");
        repeat (3) @(negedge clk);
        check(dmarq, 1'b0, "request dropped on ack");
        check(dstb, 1'b1, "no edge before host ready");
        host.host_rdy(1'b1);
        repeat (24) @(negedge clk);
        check(din_n > 3, 1'b1, "words moving");
        host.host_rdy(1'b0);
        repeat (5) @(negedge clk);
        n0 = din_n;
        repeat (12) @(negedge clk);
        check(din_n, n0, "paused");
        check(din_n, tx_n, "all taken words sent");
        host.finish_burst();
        xfer = 1'b0;
        repeat (4) @(negedge clk);
        check({active, oe}, 2'b00, "burst ended");
        $display("data-in test done");
    endtask : t_din
    // Data-out burst, then a stall of the core fills the slot.
    task automatic t_dout;
        dir_in = 1'b0;
        rx_rdy = 1'b1;
        xfer = 1'b1;
        repeat (3) @(negedge clk);
        check(ddmardy_n, 1'b1, "ready only under ack");
        host.ack(ok);
        check(ok, 1'b1, "request raised again");
        repeat (4) @(negedge clk);
        check(ddmardy_n, 1'b0, "device ready");
        host.send(4, 16'h5000);
        check(rx_n, 4, "four words");
        rx_rdy = 1'b0;
        host.send(1, 16'h5004);
        repeat (4) @(negedge clk);
        check(ddmardy_n, 1'b1, "device paused");
        rx_rdy = 1'b1;
        repeat (4) @(negedge clk);
        check(rx_n, 5, "stalled word delivered");
        host.finish_burst();
        xfer = 1'b0;
        repeat (4) @(negedge clk);
        check({active, ddmardy_n}, 2'b01, "burst ended");
        $display("data-out test done");
    endtask : t_dout
    initial begin
        {rst_n, csel, xfer, dir_in, reg_rdy, tx_valid, rx_rdy, dstb_prev} = 8'h01;
        t_strap();
        t_reg();
        t_din();
        t_dout();
        results();
    end
    // Watchdog: the whole run needs well under 1500 cycles.
    initial begin
        repeat (1500) @(posedge clk);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : test_ata_dma_handshake_port
